// *** design/hies_pkg.sv ***
// package: register map, field positions and types of the host interrupt enable/status block
package hies_pkg;

   // register byte offsets
   localparam logic [11:0] OFS_ENABLE = 12'h300;
   localparam logic [11:0] OFS_STATUS = 12'h304;
   localparam logic [11:0] OFS_VCAP_BASE = 12'h340;
   localparam logic [11:0] OFS_SRC_LEVEL = 12'h360;

   // field positions shared by enable and status
   localparam int BIT_LM0 = 20;
   localparam int BIT_MAILBOX_0 = 16;
   localparam int BIT_ACFAIL = 15;
   localparam int BIT_SYSFAIL = 14;
   localparam int BIT_SOFT = 13;
   localparam int BIT_SOFT_ACK = 12;
   localparam int BIT_VME_BUS_ERROR = 10;
   localparam int BIT_PCI_BUS_ERROR = 9;
   localparam int BIT_DMA = 8;
   localparam int BIT_LVL1 = 1;
   localparam int BIT_OWN = 0;

   // implemented bits; 31-24 and 11 reserved, read zero
   localparam logic [31:0] IMPL_MASK = 32'h00ff_f7ff;

   // values after reset
   localparam logic [31:0] ENABLE_RST = 32'h0000_0000;
   localparam logic [31:0] STATUS_RST = 32'h0000_0000;
   localparam logic [7:0] VCAP_RST = 8'h00;

   // widths
   localparam int VEC_W = 8;
   localparam int NUM_LVL = 7;

   // interrupt acknowledge engine states
   typedef enum logic [1:0] {
      HIES_IDLE,
      HIES_BUSREQ,
      HIES_ACK,
      HIES_DONE
   } hies_state_e;

   // byte enables widened to a bit mask
   function automatic logic [31:0] hies_be_mask(input logic [3:0] be);
      hies_be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

endpackage

// *** design/hies_sticky_bits.sv ***
// sticky status bits: set wins over a write-one clear
`timescale 1ns/1ps
`default_nettype none
module hies_sticky_bits #(
   parameter int W = 32
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // set and clear strobes per bit
   input wire logic [W-1:0] set_i,
   input wire logic [W-1:0] clr_i,
   // latched status
   output logic [W-1:0] status_o
);
   import hies_pkg::*;

   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         // one flop per bit; a set in the clear cycle survives
         always_ff @(posedge ref_clk_i) begin
            if (!rst_n_i) begin
               status_o[g] <= STATUS_RST[g];
            end else if (set_i[g]) begin
               status_o[g] <= 1'b1;
            end else if (clr_i[g]) begin
               status_o[g] <= 1'b0;
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

// *** design/hies_iack_engine.sv ***
// vme interrupt handler: bus request, acknowledge cycle, vector capture
`timescale 1ns/1ps
`default_nettype none
module hies_iack_engine (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // level qualifiers, index = level
   input wire logic [7:1] lvl_enable_i,
   input wire logic [7:1] lvl_irq_i,
   input wire logic [7:1] lvl_pending_i,
   // vme bus side
   input wire logic bus_grant_i,
   input wire logic iack_done_i,
   input wire logic [7:0] iack_vector_i,
   output logic bus_req_o,
   output logic iack_o,
   output logic [2:0] iack_level_o,
   // capture result
   output logic cap_valid_o,
   output logic [7:0] cap_vector_o
);
   import hies_pkg::*;

   hies_state_e state;
   logic [7:1] eligible;
   logic [2:0] pick;

   // only enabled, asserted, not already pending levels compete
   assign eligible = lvl_enable_i & lvl_irq_i & ~lvl_pending_i;

   // highest level wins
   always_comb begin
      pick = 3'h0;
      for (int l = 1; l <= NUM_LVL; l++) begin
         if (eligible[l]) begin
            pick = 3'(l);
         end
      end
   end

   // sequence one acknowledge cycle at a time
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         state <= HIES_IDLE;
         bus_req_o <= 1'b0;
         iack_o <= 1'b0;
         iack_level_o <= 3'h0;
         cap_valid_o <= 1'b0;
         cap_vector_o <= VCAP_RST;
      end else begin
         unique case (state)
            HIES_IDLE: begin
               cap_valid_o <= 1'b0;
               if (pick != 3'h0) begin
                  bus_req_o <= 1'b1;
                  iack_level_o <= pick;
                  state <= HIES_BUSREQ;
               end
            end
            HIES_BUSREQ: begin
               if (bus_grant_i) begin
                  iack_o <= 1'b1;
                  state <= HIES_ACK;
               end
            end
            HIES_ACK: begin
               if (iack_done_i) begin
                  iack_o <= 1'b0;
                  bus_req_o <= 1'b0;
                  cap_valid_o <= 1'b1;
                  cap_vector_o <= iack_vector_i;
                  state <= HIES_DONE;
               end
            end
            HIES_DONE: begin
               cap_valid_o <= 1'b0;
               state <= HIES_IDLE;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// *** design/hies_top.sv ***
// host interrupt enable/status block with vme interrupt handler and avalon-mm slave
// Summary of operation
// - four location monitor enables mask at 0, pass at 1, reset 0
// - four mailbox enables mask at 0, pass at 1, reset 0
// - acfail and sysfail enables block at 0, enable at 1, reset 0
// - writing soft interrupt enable from 0 to 1 sets soft interrupt
// - clearing soft enable masks it, latched soft status stays
// - soft ack, vme error, pci error, dma, ownership enables gate sources
// - level enables 7-1 choose which vme levels are handled
// - enabled asserted level: request bus, acknowledge exactly that level
// - on completion store vector, set level status, raise host interrupt
// - no new acknowledge on a level while its status is set
// - status at 304: 23-16 lm/mbox, 15-08 misc, 07-00 levels/ownership
// - enable at 300 shares status layout; 31-24 and 11 reserved
// - status latches on event edge, cleared only by writing one
// - acfail/sysfail status set by level, held after release; clear ignored while asserted
`timescale 1ns/1ps
`default_nettype none
module hies_top (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // avalon-mm slave
   input wire logic [11:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // interrupt sources, active high levels
   input wire logic [3:0] location_monitor_i,
   input wire logic [3:0] mailbox_i,
   input wire logic acfail_i,
   input wire logic sysfail_i,
   input wire logic soft_ack_event_i,
   input wire logic vme_bus_error_i,
   input wire logic pci_bus_error_i,
   input wire logic dma_i,
   input wire logic bus_ownership_i,
   // vme interrupt request lines, index = level, high = asserted
   input wire logic [7:1] vme_irq_i,
   // vme bus ownership and acknowledge handshake
   input wire logic bus_grant_i,
   input wire logic iack_done_i,
   input wire logic [7:0] iack_vector_i,
   output logic bus_req_o,
   output logic iack_o,
   output logic [2:0] iack_level_o,
   // host interrupt
   output logic host_irq_o
);
   import hies_pkg::*;

   // register state
   logic [31:0] host_irq_enable;
   logic [31:0] host_irq_status;
   logic [7:0] vector_capture [1:7];

   // bus decode
   logic wr_go;
   logic [31:0] wr_mask;
   logic hit_enable;
   logic hit_status;
   logic hit_vcap;
   logic hit_src;
   logic [2:0] vcap_idx;
   logic [31:0] next_readdata;

   // event detection
   logic [31:0] edge_src;
   logic [31:0] edge_prev;
   logic [31:0] status_set;
   logic [31:0] status_clr;
   logic soft_rise;

   // engine result
   logic cap_valid;
   logic [7:0] cap_vector;

   // address decode
   assign hit_enable = (avs_address_i[11:2] == OFS_ENABLE[11:2]);
   assign hit_status = (avs_address_i[11:2] == OFS_STATUS[11:2]);
   assign hit_vcap = (avs_address_i[11:5] == OFS_VCAP_BASE[11:5]);
   assign hit_src = (avs_address_i[11:2] == OFS_SRC_LEVEL[11:2]);
   assign vcap_idx = avs_address_i[4:2];

   // a transfer completes on the edge that sees waitrequest low
   assign wr_go = avs_write_i && !avs_waitrequest_o;
   assign wr_mask = hies_be_mask(avs_byteenable_i);

   // waitrequest: high when idle, low for one cycle to answer
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         avs_waitrequest_o <= 1'b1;
      end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
         avs_waitrequest_o <= 1'b0;
      end else begin
         avs_waitrequest_o <= 1'b1;
      end
   end

   // read multiplexer; unmapped and reserved read zero
   always_comb begin
      next_readdata = 32'h0000_0000;
      if (hit_enable) begin
         next_readdata = host_irq_enable & IMPL_MASK;
      end else if (hit_status) begin
         next_readdata = host_irq_status & IMPL_MASK;
      end else if (hit_vcap && vcap_idx != 3'h0) begin
         next_readdata = {24'h00_0000, vector_capture[vcap_idx]};
      end else if (hit_src) begin
         next_readdata[BIT_LM0 +: 4] = location_monitor_i;
         next_readdata[BIT_MAILBOX_0 +: 4] = mailbox_i;
         next_readdata[BIT_ACFAIL] = acfail_i;
         next_readdata[BIT_SYSFAIL] = sysfail_i;
         next_readdata[BIT_SOFT_ACK] = soft_ack_event_i;
         next_readdata[BIT_VME_BUS_ERROR] = vme_bus_error_i;
         next_readdata[BIT_PCI_BUS_ERROR] = pci_bus_error_i;
         next_readdata[BIT_DMA] = dma_i;
         next_readdata[BIT_LVL1 +: NUM_LVL] = vme_irq_i;
         next_readdata[BIT_OWN] = bus_ownership_i;
      end
   end

   // read data loaded when the request is first seen, held to completion
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (avs_read_i && avs_waitrequest_o) begin
         avs_readdata_o <= next_readdata;
      end
   end

   // enable register, byte-lane writes, reserved bits kept zero
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         host_irq_enable <= ENABLE_RST;
      end else if (wr_go && hit_enable) begin
         host_irq_enable <= ((host_irq_enable & ~wr_mask) | (avs_writedata_i & wr_mask)) & IMPL_MASK;
      end
   end

   // soft interrupt fires on a 0-to-1 write of its enable bit only
   assign soft_rise = wr_go && hit_enable && wr_mask[BIT_SOFT] && avs_writedata_i[BIT_SOFT]
                      && !host_irq_enable[BIT_SOFT];

   // edge-sensitive sources gathered into status layout
   always_comb begin
      edge_src = 32'h0000_0000;
      edge_src[BIT_LM0 +: 4] = location_monitor_i;
      edge_src[BIT_MAILBOX_0 +: 4] = mailbox_i;
      edge_src[BIT_SOFT_ACK] = soft_ack_event_i;
      edge_src[BIT_VME_BUS_ERROR] = vme_bus_error_i;
      edge_src[BIT_PCI_BUS_ERROR] = pci_bus_error_i;
      edge_src[BIT_DMA] = dma_i;
      edge_src[BIT_OWN] = bus_ownership_i;
   end

   // previous source levels for rising-edge detection
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         edge_prev <= 32'h0000_0000;
      end else begin
         edge_prev <= edge_src;
      end
   end

   // status set terms: edges, held levels, soft write, finished acknowledge
   always_comb begin
      status_set = edge_src & ~edge_prev;
      status_set[BIT_ACFAIL] = acfail_i;
      status_set[BIT_SYSFAIL] = sysfail_i;
      status_set[BIT_SOFT] = soft_rise;
      status_set[BIT_LVL1 +: NUM_LVL] = 7'h00;
      if (cap_valid) begin
         status_set[BIT_LVL1 - 1 + int'(iack_level_o)] = 1'b1;
      end
      status_set = status_set & IMPL_MASK;
   end

   // write-one clear on the status register, per byte lane
   assign status_clr = (wr_go && hit_status) ? (avs_writedata_i & wr_mask) : 32'h0000_0000;

   // latched status bits
   hies_sticky_bits #(
      .W(32)
   ) u_status (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .set_i(status_set),
      .clr_i(status_clr),
      .status_o(host_irq_status)
   );

   // vme interrupt handler, blocked per level while status is set
   hies_iack_engine u_iack (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .lvl_enable_i(host_irq_enable[BIT_LVL1 +: NUM_LVL]),
      .lvl_irq_i(vme_irq_i),
      .lvl_pending_i(host_irq_status[BIT_LVL1 +: NUM_LVL]),
      .bus_grant_i(bus_grant_i),
      .iack_done_i(iack_done_i),
      .iack_vector_i(iack_vector_i),
      .bus_req_o(bus_req_o),
      .iack_o(iack_o),
      .iack_level_o(iack_level_o),
      .cap_valid_o(cap_valid),
      .cap_vector_o(cap_vector)
   );

   // vector capture per level
   genvar g;
   generate
      for (g = 1; g <= NUM_LVL; g++) begin : g_vcap
         always_ff @(posedge ref_clk_i) begin
            if (!rst_n_i) begin
               vector_capture[g] <= VCAP_RST;
            end else if (cap_valid && iack_level_o == 3'(g)) begin
               vector_capture[g] <= cap_vector;
            end
         end
      end
   endgenerate

   // host interrupt: any enabled and pending bit
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         host_irq_o <= 1'b0;
      end else begin
         host_irq_o <= |(host_irq_status & host_irq_enable & IMPL_MASK);
      end
   end

endmodule
`default_nettype wire

// *** dv/hies_checker.sv ***
// port checker for the host interrupt block
`timescale 1ns/1ps
`default_nettype none
module hies_checker
   import hies_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // register bus
   input wire logic [11:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   // handler and interrupt
   input wire logic [7:1] vme_irq_i,
   input wire logic bus_grant_i,
   input wire logic iack_done_i,
   input wire logic bus_req_o,
   input wire logic iack_o,
   input wire logic [2:0] iack_level_o,
   input wire logic host_irq_o
);
   logic [31:0] en_q;
   logic [7:0] cand_q;
   logic [7:0] pend_q;
   logic [7:0] clr;
   logic wr_ok;
   // completed writes and level clears
   assign wr_ok = avs_write_i && !avs_waitrequest_o;
   assign clr = (wr_ok && avs_address_i == OFS_STATUS && avs_byteenable_i[0]) ? {avs_writedata_i[7:1], 1'b0} : 8'h00;
   // mirror of enables, eligible levels and acknowledged levels
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         en_q <= 32'h0000_0000;
         cand_q <= 8'h00;
         pend_q <= 8'h00;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (wr_ok && avs_address_i == OFS_ENABLE && avs_byteenable_i[i]) begin
               en_q[8*i +: 8] <= avs_writedata_i[8*i +: 8];
            end
         end
         cand_q <= {vme_irq_i & en_q[7:1], 1'b0};
         pend_q <= (pend_q & ~clr) | ((iack_o && iack_done_i) ? 8'h01 << iack_level_o : 8'h00);
      end
   end
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_taken;
      (avs_read_i || avs_write_i) && avs_waitrequest_o;
   endsequence
   sequence s_done;
      iack_o && iack_done_i;
   endsequence
   bus_answer_a: assert property (s_taken |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
      else $error("bus answer not one cycle");
   reset_quiet_a: assert property ($rose(rst_n_i) |-> avs_waitrequest_o && !host_irq_o && !bus_req_o)
      else $error("outputs not idle after reset");
   reserved_zero_a: assert property (
      avs_read_i && !avs_waitrequest_o && avs_address_i[11:3] == OFS_ENABLE[11:3] |-> (avs_readdata_o & ~IMPL_MASK) == 32'h0)
      else $error("reserved bits read nonzero");
   level_start_a: assert property ($rose(bus_req_o) |-> cand_q[iack_level_o])
      else $error("handler started on an ineligible level");
   no_reack_a: assert property ($rose(bus_req_o) |-> !pend_q[iack_level_o])
      else $error("level acknowledged again while pending");
   iack_grant_a: assert property ($rose(iack_o) |-> bus_req_o && $past(bus_grant_i))
      else $error("acknowledge without grant");
   level_hold_a: assert property (
      bus_req_o && !(iack_o && iack_done_i) |=> bus_req_o && $stable(iack_level_o))
      else $error("request or level dropped early");
   iack_end_a: assert property (s_done |=> (!iack_o && !bus_req_o) [*2])
      else $error("acknowledge not closed");
   irq_cause_a: assert property (host_irq_o |-> $past(en_q) != 32'h0)
      else $error("interrupt with all sources masked");
endmodule
`default_nettype wire

// *** dv/hies_vme_partner.sv ***
// vme interrupter and arbiter model
`timescale 1ns/1ps
`default_nettype none
module hies_vme_partner (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // bench commands: raise a level, grant delay
   input wire logic [7:1] raise_i,
   input wire logic [2:0] delay_i,
   // handler side
   input wire logic bus_req_i,
   input wire logic iack_i,
   input wire logic [2:0] iack_level_i,
   output logic [7:1] vme_irq_o,
   output logic bus_grant_o,
   output logic iack_done_o,
   output logic [7:0] iack_vector_o
);
   logic [2:0] cnt_q;
   // lines release once acknowledged; vector only valid with done
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         vme_irq_o <= 7'h00;
         bus_grant_o <= 1'b0;
         iack_done_o <= 1'b0;
         iack_vector_o <= 8'h00;
         cnt_q <= 3'h0;
      end else begin
         vme_irq_o <= (vme_irq_o | raise_i) & ~(iack_done_o ? 7'h01 << (iack_level_i - 3'h1) : 7'h00);
         cnt_q <= (bus_req_i && cnt_q != 3'h7) ? cnt_q + 3'h1 : (bus_req_i ? cnt_q : 3'h0);
         bus_grant_o <= bus_req_i && cnt_q >= delay_i;
         iack_done_o <= iack_i && !iack_done_o;
         iack_vector_o <= (iack_i && !iack_done_o) ? {5'h10, iack_level_i} : ~iack_vector_o;
      end
   end
endmodule
`default_nettype wire

// *** dv/hies_top_bench.sv ***
// self-checking bench for the host interrupt block
`timescale 1ns/1ps
`default_nettype none
module hies_top_bench;
   import hies_pkg::*;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [11:0] adr = 12'h000;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [31:0] src = 32'h0;
   logic [7:1] raise = 7'h00;
   logic [2:0] dly = 3'h0;
   logic [31:0] rdata;
   logic [7:1] virq;
   logic [7:0] vec;
   logic [2:0] lvl;
   logic wreq, grant, done, breq, iack, irq;
   int compares = 0;
   int fail_count = 0;
   // clock
   always #12.5 ref_clk_i = ~ref_clk_i;
   hies_top u_hies_top (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wreq), .location_monitor_i(src[23:20]), .mailbox_i(src[19:16]), .acfail_i(src[15]),
      .sysfail_i(src[14]), .soft_ack_event_i(src[12]), .vme_bus_error_i(src[10]), .pci_bus_error_i(src[9]),
      .dma_i(src[8]), .bus_ownership_i(src[0]), .vme_irq_i(virq), .bus_grant_i(grant), .iack_done_i(done),
      .iack_vector_i(vec), .bus_req_o(breq), .iack_o(iack), .iack_level_o(lvl), .host_irq_o(irq));
   hies_vme_partner u_hies_vme_partner (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .raise_i(raise),
      .delay_i(dly), .bus_req_i(breq), .iack_i(iack), .iack_level_i(lvl), .vme_irq_o(virq),
      .bus_grant_o(grant), .iack_done_o(done), .iack_vector_o(vec));
   // compare and verdict
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // one avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge ref_clk_i);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= d;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (wreq !== 1'b0 && n < 20);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (wreq !== 1'b0) begin
         check(32'h1, 32'h0);
         report_and_stop();
      end
   endtask
   task automatic wr32(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check(q, e);
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask
   task automatic wait_irq();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 200) begin
         @(negedge ref_clk_i);
         n++;
      end
      if (irq !== 1'b1) begin
         check(32'h1, 32'h0);
         report_and_stop();
      end
   endtask
   // main sequence
   initial begin
      logic [31:0] edge_set;
      edge_set = 32'h00ff_1701;
      repeat (3) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      rd_chk(OFS_ENABLE, 32'h0);
      rd_chk(OFS_STATUS, 32'h0);
      // soft interrupt from enable write
      wr32(OFS_ENABLE, 32'hffff_ffff);
      rd_chk(OFS_ENABLE, 32'h00ff_f7ff);
      rd_chk(OFS_STATUS, 32'h0000_2000);
      step(2);
      check({31'h0, irq}, 32'h1);
      wr32(OFS_ENABLE, 32'h00ff_d7ff);
      rd_chk(OFS_STATUS, 32'h0000_2000);
      step(2);
      check({31'h0, irq}, 32'h0);
      wr32(OFS_STATUS, 32'hffff_ffff);
      rd_chk(OFS_STATUS, 32'h0);
      wr32(OFS_ENABLE, 32'h0);
      // edge sources: masked, enabled, cleared while source held
      for (int b = 0; b < 24; b++) begin
         if (edge_set[b]) begin
            @(posedge ref_clk_i);
            src[b] <= 1'b1;
            rd_chk(OFS_STATUS, 32'h1 << b);
            check({31'h0, irq}, 32'h0);
            wr32(OFS_ENABLE, 32'h1 << b);
            step(2);
            check({31'h0, irq}, 32'h1);
            wr32(OFS_STATUS, 32'h1 << b);
            rd_chk(OFS_STATUS, 32'h0);
            step(2);
            check({31'h0, irq}, 32'h0);
            src[b] <= 1'b0;
            wr32(OFS_ENABLE, 32'h0);
         end
      end
      // level sources ignore a clear while held
      for (int b = 14; b < 16; b++) begin
         @(posedge ref_clk_i);
         src[b] <= 1'b1;
         wr32(OFS_STATUS, 32'h1 << b);
         rd_chk(OFS_STATUS, 32'h1 << b);
         rd_chk(OFS_SRC_LEVEL, 32'h1 << b);
         wr32(OFS_ENABLE, 32'h1 << b);
         step(2);
         check({31'h0, irq}, 32'h1);
         src[b] <= 1'b0;
         wr32(OFS_STATUS, 32'h1 << b);
         rd_chk(OFS_STATUS, 32'h0);
         wr32(OFS_ENABLE, 32'h0);
      end
      // vme level 5 with slow grant
      dly <= 3'h6;
      raise <= 7'h10;
      step(1);
      raise <= 7'h00;
      step(10);
      check({31'h0, breq}, 32'h0);
      wr32(OFS_ENABLE, 32'h0000_0020);
      wait_irq();
      rd_chk(OFS_STATUS, 32'h0000_0020);
      rd_chk(12'h354, 32'h0000_0085);
      raise <= 7'h10;
      step(1);
      raise <= 7'h00;
      step(12);
      check({31'h0, breq}, 32'h0);
      wr32(OFS_STATUS, 32'h0000_0020);
      step(3);
      wait_irq();
      rd_chk(OFS_STATUS, 32'h0000_0020);
      // levels 6 and 2 together, prompt grant
      dly <= 3'h0;
      wr32(OFS_STATUS, 32'h0000_0020);
      wr32(OFS_ENABLE, 32'h0000_0044);
      raise <= 7'h22;
      step(1);
      raise <= 7'h00;
      step(40);
      rd_chk(OFS_STATUS, 32'h0000_0044);
      rd_chk(12'h358, 32'h0000_0086);
      rd_chk(12'h348, 32'h0000_0082);
      // mid-run reset clears enables, status and interrupt
      @(posedge ref_clk_i);
      rst_n_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      rd_chk(OFS_ENABLE, 32'h0);
      rd_chk(OFS_STATUS, 32'h0);
      check({31'h0, irq}, 32'h0);
      // unmapped place
      wr32(12'h3f0, 32'hffff_ffff);
      rd_chk(12'h3f0, 32'h0);
      report_and_stop();
   end
endmodule
bind hies_top hies_checker u_hies_checker (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
   .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .vme_irq_i(vme_irq_i), .bus_grant_i(bus_grant_i),
   .iack_done_i(iack_done_i), .bus_req_o(bus_req_o), .iack_o(iack_o), .iack_level_o(iack_level_o),
   .host_irq_o(host_irq_o));
`default_nettype wire
